// ### inc/tal_pkg.sv
package tal_pkg;
    // Temperature width, unsigned degrees Celsius
    localparam int TW = 8;
    // Power-up fail-safe limits (85 C) and hysteresis (10 C)
    localparam logic [7:0] HOT_LIMIT_RST = 8'h55;
    localparam logic [7:0] HYST_RST = 8'h0a;
    // Alert response address, binary 0001 100
    localparam logic [6:0] ARA_ADDR = 7'h0c;
    localparam logic READ_BIT = 1'b1;
    localparam logic ANSWER_LSB = 1'b1;
    // Selects of the internal write port
    localparam logic [1:0] SEL_LOCAL_HOT = 2'h0;
    localparam logic [1:0] SEL_REMOTE_HOT = 2'h1;
    localparam logic [1:0] SEL_HYST = 2'h2;
    // Status bit positions
    localparam int ST_LOCAL_HIGH = 6;
    localparam int ST_LOCAL_LOW = 5;
    localparam int ST_REMOTE_HIGH = 4;
    localparam int ST_REMOTE_LOW = 3;
    localparam int ST_OPEN = 2;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // Default conversion spacing in clock cycles
    localparam int CONV_PERIOD_DEF = 1000;
    // Last bit index of a serial byte
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam int N_CMP = 4;

    typedef enum logic [1:0] {
        TAL_CONV_IDLE = 2'b01,
        TAL_CONV_RUN = 2'b10
    } tal_conv_e;

    typedef enum logic [5:0] {
        TAL_BUS_IDLE = 6'b000001,
        TAL_BUS_ADDR = 6'b000010,
        TAL_BUS_ACK = 6'b000100,
        TAL_BUS_ACKH = 6'b001000,
        TAL_BUS_SEND = 6'b010000,
        TAL_BUS_TAIL = 6'b100000
    } tal_bus_e;

    typedef struct packed {
        logic [TW-1:0] local_t;
        logic [TW-1:0] remote_t;
    } tal_temps_s;

    typedef struct packed {
        logic [TW-1:0] local_high;
        logic [TW-1:0] local_low;
        logic [TW-1:0] remote_high;
        logic [TW-1:0] remote_low;
    } tal_limits_s;
endpackage

// ### rtl/tal_alarm.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Alarm low on limit violation or open sensor
// - Answer alert response read while alarm held
// - Answer byte is own address, LSB one
// - Arbitrate answer; loser keeps alarm asserted
// - Release after answer only if cause gone
// - Standby inhibits and aborts conversions, no update
// - One-shot write in standby converts once
// - New limits re-check stored values in standby
// - Sample open comparator at conversion start
// - Open flag drives alarm in alarm mode
// - Alarm maskable; fail-safe output never masked
// - Above high or at/below low alarms
// - Release needs answer, cause gone, status cleared
// - Fail-safe low when temperature exceeds limit
// - Fail-safe releases at limit minus hysteresis
// - Fail-safe limits reset to 85 C
// - Hysteresis in whole degrees, reset 10 C
// - Shared pin selects alarm or second fail-safe
// - Second fail-safe on high limits, unmaskable
// - Same hysteresis governs second fail-safe release
// - Pins only pull low or release
module tal_alarm #(
    parameter int CONV_PERIOD = tal_pkg::CONV_PERIOD_DEF
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [6:0] own_addr,
    input wire logic cfg_standby,
    input wire logic cfg_alert_mask,
    input wire logic cfg_second_hot,
    input wire logic one_shot_wr,
    input wire tal_pkg::tal_limits_s limits,
    input wire logic status_clear,
    input wire logic reg_wr,
    input wire logic [1:0] reg_sel,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] local_hot_limit,
    output logic [7:0] remote_hot_limit,
    output logic [7:0] hyst,
    output logic conv_start,
    output logic conv_abort,
    input wire logic conv_done,
    input wire tal_pkg::tal_temps_s meas,
    input wire logic open_cmp_i,
    output tal_pkg::tal_temps_s values,
    output logic [7:0] status,
    output logic ara_won,
    output logic failsafe_hot_n_o,
    output logic failsafe_hot_n_oe,
    output logic shared_n_o,
    output logic shared_n_oe
);
    localparam int CW = $clog2(CONV_PERIOD + 1);
    localparam logic [CW-1:0] TIMER_LAST = CW'(CONV_PERIOD - 1);
    localparam logic [CW-1:0] TIMER_ONE = CW'(1);

    logic [2:0] pin_s;
    logic scl_s;
    logic sda_s;
    logic open_s;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    tal_pkg::tal_conv_e conv_st;
    tal_pkg::tal_bus_e bus_st;
    logic [CW-1:0] timer;
    logic timer_done;
    logic oneshot_run;
    logic start_now;
    logic open_seen;
    logic [7:0] viol;
    logic [7:0] set_vec;
    logic cond_now;
    logic alarm_event;
    logic alarm_active;
    logic ara_served;
    logic respond;
    logic [3:0] bit_cnt;
    logic [6:0] shift_in;
    logic [7:0] tx;
    logic [tal_pkg::TW-1:0] cmp_temp [tal_pkg::N_CMP];
    logic [tal_pkg::TW-1:0] cmp_lim [tal_pkg::N_CMP];
    logic [tal_pkg::N_CMP-1:0] hot;

    // Bus pins and the open comparator are asynchronous to sys_clk
    tal_sync2 #(
        .W(3)
    ) u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        // Bus pins enter inverted so reset reads idle high, no false edge
        .d({~scl_i, ~sda_i, open_cmp_i}),
        .q(pin_s)
    );
    assign scl_s = ~pin_s[2];
    assign sda_s = ~pin_s[1];
    assign open_s = pin_s[0];

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_cond = scl_s & scl_q & ~sda_q & sda_s;

    // Fail-safe limits and hysteresis
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            local_hot_limit <= tal_pkg::HOT_LIMIT_RST;
            remote_hot_limit <= tal_pkg::HOT_LIMIT_RST;
            hyst <= tal_pkg::HYST_RST;
        end
        else if (reg_wr)
        begin
            case (reg_sel)
                tal_pkg::SEL_LOCAL_HOT: local_hot_limit <= reg_wdata;
                tal_pkg::SEL_REMOTE_HOT: remote_hot_limit <= reg_wdata;
                tal_pkg::SEL_HYST: hyst <= reg_wdata;
                default: hyst <= hyst;
            endcase
        end
    end

    // Conversion sequencing
    assign timer_done = (timer == TIMER_LAST);
    assign start_now = (conv_st == tal_pkg::TAL_CONV_IDLE)
        && (one_shot_wr || (!cfg_standby && timer_done));

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            conv_st <= tal_pkg::TAL_CONV_IDLE;
            timer <= '0;
            oneshot_run <= 1'b0;
            conv_start <= 1'b0;
            conv_abort <= 1'b0;
        end
        else
        begin
            conv_start <= start_now;
            conv_abort <= 1'b0;
            case (conv_st)
                tal_pkg::TAL_CONV_IDLE:
                begin
                    if (start_now)
                    begin
                        conv_st <= tal_pkg::TAL_CONV_RUN;
                        oneshot_run <= cfg_standby;
                        timer <= '0;
                    end
                    else if (!cfg_standby)
                        timer <= timer + TIMER_ONE;
                end
                tal_pkg::TAL_CONV_RUN:
                begin
                    if (conv_done)
                        conv_st <= tal_pkg::TAL_CONV_IDLE;
                    else if (cfg_standby && !oneshot_run)
                    begin
                        conv_abort <= 1'b1;
                        conv_st <= tal_pkg::TAL_CONV_IDLE;
                    end
                end
                default: conv_st <= tal_pkg::TAL_CONV_IDLE;
            endcase
        end
    end

    // Results land only from a conversion that ran to completion
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            values <= '0;
        else if ((conv_st == tal_pkg::TAL_CONV_RUN) && conv_done)
            values <= meas;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            open_seen <= 1'b0;
        else if (start_now)
            open_seen <= open_s;
    end

    // Compared every cycle, so a limit write re-checks stored values
    always_comb
    begin
        viol = '0;
        viol[tal_pkg::ST_LOCAL_HIGH] = values.local_t > limits.local_high;
        viol[tal_pkg::ST_LOCAL_LOW] = values.local_t <= limits.local_low;
        viol[tal_pkg::ST_REMOTE_HIGH] = values.remote_t > limits.remote_high;
        viol[tal_pkg::ST_REMOTE_LOW] = values.remote_t <= limits.remote_low;
        set_vec = viol;
        set_vec[tal_pkg::ST_OPEN] = start_now & open_s;
    end

    assign cond_now = (|viol) | open_seen;

    // Set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            status <= tal_pkg::STATUS_RST;
        else
            status <= (status_clear ? tal_pkg::STATUS_RST : status) | set_vec;
    end

    // Only newly raised flags count, so a standing cause cannot keep clearing ara_served
    assign alarm_event = (|(set_vec & ~status)) && !cfg_alert_mask;
    assign respond = alarm_active && !cfg_second_hot;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            alarm_active <= 1'b0;
            ara_served <= 1'b0;
        end
        else
        begin
            if (alarm_event)
                ara_served <= 1'b0;
            else if (ara_won)
                ara_served <= 1'b1;
            if (alarm_event)
                alarm_active <= 1'b1;
            else if (ara_served && !cond_now && (status == tal_pkg::STATUS_RST))
                alarm_active <= 1'b0;
        end
    end

    // Fail-safe comparators: 0/1 primary, 2/3 second output
    assign cmp_temp[0] = values.local_t;
    assign cmp_temp[1] = values.remote_t;
    assign cmp_temp[2] = values.local_t;
    assign cmp_temp[3] = values.remote_t;
    assign cmp_lim[0] = local_hot_limit;
    assign cmp_lim[1] = remote_hot_limit;
    assign cmp_lim[2] = limits.local_high;
    assign cmp_lim[3] = limits.remote_high;

    generate
        for (genvar i = 0; i < tal_pkg::N_CMP; i++)
        begin : g_hot
            tal_hot_cmp #(
                .W(tal_pkg::TW)
            ) u_cmp (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .temp(cmp_temp[i]),
                .limit(cmp_lim[i]),
                .hyst(hyst),
                .hot(hot[i])
            );
        end
    endgenerate

    // Open-drain pins: drive level fixed low, only the enable moves
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            failsafe_hot_n_o <= 1'b0;
            failsafe_hot_n_oe <= 1'b0;
            shared_n_o <= 1'b0;
            shared_n_oe <= 1'b0;
            sda_o <= 1'b0;
        end
        else
        begin
            failsafe_hot_n_o <= 1'b0;
            shared_n_o <= 1'b0;
            sda_o <= 1'b0;
            failsafe_hot_n_oe <= hot[0] | hot[1];
            shared_n_oe <= cfg_second_hot ? (hot[2] | hot[3]) : alarm_active;
        end
    end

    // Alert response answer; host repetition is its own business
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bus_st <= tal_pkg::TAL_BUS_IDLE;
            bit_cnt <= tal_pkg::BIT_FIRST;
            shift_in <= '0;
            tx <= '0;
            sda_oe <= 1'b0;
            ara_won <= 1'b0;
        end
        else
        begin
            ara_won <= 1'b0;
            if (stop_cond)
            begin
                bus_st <= tal_pkg::TAL_BUS_IDLE;
                sda_oe <= 1'b0;
            end
            else if (start_cond)
            begin
                bus_st <= tal_pkg::TAL_BUS_ADDR;
                bit_cnt <= tal_pkg::BIT_FIRST;
                sda_oe <= 1'b0;
            end
            else
            begin
                case (bus_st)
                    tal_pkg::TAL_BUS_IDLE: sda_oe <= 1'b0;
                    tal_pkg::TAL_BUS_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            shift_in <= {shift_in[5:0], sda_s};
                            bit_cnt <= 4'(bit_cnt + 4'h1);
                            if (bit_cnt == tal_pkg::BIT_LAST)
                                bus_st <= (({shift_in, sda_s} == {tal_pkg::ARA_ADDR,
                                    tal_pkg::READ_BIT}) && respond)
                                    ? tal_pkg::TAL_BUS_ACK : tal_pkg::TAL_BUS_IDLE;
                        end
                    end
                    tal_pkg::TAL_BUS_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe <= 1'b1;
                            bus_st <= tal_pkg::TAL_BUS_ACKH;
                        end
                    end
                    tal_pkg::TAL_BUS_ACKH:
                    begin
                        if (scl_fall)
                        begin
                            tx <= {own_addr, tal_pkg::ANSWER_LSB};
                            sda_oe <= ~own_addr[6];
                            bit_cnt <= tal_pkg::BIT_FIRST;
                            bus_st <= tal_pkg::TAL_BUS_SEND;
                        end
                    end
                    tal_pkg::TAL_BUS_SEND:
                    begin
                        if (scl_rise)
                        begin
                            if (tx[7] && !sda_s)
                            begin
                                sda_oe <= 1'b0;
                                bus_st <= tal_pkg::TAL_BUS_IDLE;
                            end
                            else if (bit_cnt == tal_pkg::BIT_LAST)
                            begin
                                ara_won <= 1'b1;
                                bus_st <= tal_pkg::TAL_BUS_TAIL;
                            end
                            else
                                bit_cnt <= 4'(bit_cnt + 4'h1);
                        end
                        else if (scl_fall)
                        begin
                            tx <= {tx[6:0], 1'b0};
                            sda_oe <= ~tx[6];
                        end
                    end
                    tal_pkg::TAL_BUS_TAIL:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe <= 1'b0;
                            bus_st <= tal_pkg::TAL_BUS_IDLE;
                        end
                    end
                    default: bus_st <= tal_pkg::TAL_BUS_IDLE;
                endcase
            end
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    alarm_drives_pin_a: assert property (!cfg_second_hot && alarm_active |=> shared_n_oe)
        else $error("alarm active but shared pin released");
    open_sampled_start_a: assert property (start_now && open_s |=> status[tal_pkg::ST_OPEN])
        else $error("open comparator not flagged at conversion start");
    high_limit_flag_a: assert property (values.local_t > limits.local_high
        |=> status[tal_pkg::ST_LOCAL_HIGH])
        else $error("local high violation not flagged");
    failsafe_assert_a: assert property (values.remote_t > remote_hot_limit
        |-> ##2 failsafe_hot_n_oe)
        else $error("fail-safe output not pulled low");
    hot_release_a: assert property (hot[0] && !(values.local_t > local_hot_limit)
        && ({1'b0, values.local_t} + {1'b0, hyst} <= {1'b0, local_hot_limit})
        |=> !hot[0])
        else $error("fail-safe did not release below hysteresis");
    standby_abort_a: assert property (conv_st == tal_pkg::TAL_CONV_RUN && cfg_standby
        && !oneshot_run && !conv_done |=> conv_abort)
        else $error("standby did not abort conversion");
    idle_value_hold_a: assert property (conv_st == tal_pkg::TAL_CONV_IDLE
        |=> $stable(values))
        else $error("value changed without a conversion");
    oneshot_start_a: assert property (cfg_standby && one_shot_wr
        && conv_st == tal_pkg::TAL_CONV_IDLE |=> conv_start ##1 oneshot_run)
        else $error("one-shot write did not start conversion");
    answer_lsb_one_a: assert property (bus_st == tal_pkg::TAL_BUS_SEND
        && bit_cnt == tal_pkg::BIT_LAST && tx[6:0] == 7'h00
        && !scl_rise && !scl_fall |-> !sda_oe)
        else $error("answer byte LSB not released high");
    arbitration_lost_a: assert property (bus_st == tal_pkg::TAL_BUS_SEND && scl_rise
        && tx[7] && !sda_s && !start_cond && !stop_cond
        |=> !sda_oe && !ara_won && bus_st == tal_pkg::TAL_BUS_IDLE)
        else $error("lost arbitration but kept driving");
    release_needs_all_a: assert property (alarm_active && !(ara_served && !cond_now
        && status == tal_pkg::STATUS_RST) |=> alarm_active)
        else $error("alarm released too early");
    mask_blocks_alarm_a: assert property (cfg_alert_mask && !alarm_active
        |=> !alarm_active)
        else $error("masked alarm was raised");
    status_sticky_a: assert property (status[tal_pkg::ST_OPEN] && !status_clear
        |=> status[tal_pkg::ST_OPEN])
        else $error("status flag lost without a clear");
endmodule

// ### rtl/tal_hot_cmp.sv
`timescale 1ns/1ps
module tal_hot_cmp #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [W-1:0] temp,
    input wire logic [W-1:0] limit,
    input wire logic [W-1:0] hyst,
    output logic hot
);
    logic [W:0] temp_plus_hyst;

    // Widened sum; a hysteresis above the limit never releases
    assign temp_plus_hyst = {1'b0, temp} + {1'b0, hyst};

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            hot <= 1'b0;
        else if (temp > limit)
            hot <= 1'b1;
        else if (temp_plus_hyst <= {1'b0, limit})
            hot <= 1'b0;
    end
endmodule

// ### rtl/tal_sync2.sv
`timescale 1ns/1ps
module tal_sync2 #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ### verification/tal_host_model.sv
`timescale 1ns/1ps
module tal_host_model (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    localparam logic [7:0] ARA_BYTE = {tal_pkg::ARA_ADDR, tal_pkg::READ_BIT};
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        sda_pull = ~b;
        #40 scl = 1'b1;
        #40 r = sda;
        #40 scl = 1'b0;
        #40;
    endtask
    // Rival byte stands for a second answering device on the line
    task automatic ara_read(input logic [7:0] rival, output logic [7:0] d, output logic ack_n);
        logic r;
        sda_pull = 1'b1;
        #80 scl = 1'b0;
        #40;
        for (int i = 7; i >= 0; i--)
            bit_io(ARA_BYTE[i], r);
        bit_io(1'b1, ack_n);
        for (int i = 7; i >= 0; i--)
            bit_io(rival[i], d[i]);
        bit_io(1'b1, r);
        sda_pull = 1'b1;
        #40 scl = 1'b1;
        #40 sda_pull = 1'b0;
        #80;
    endtask
endmodule

// ### verification/test_temp_alarm_interrupt_logic.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
    $display("mismatch at %0t: line %0d", $time, `__LINE__); end end
module test_temp_alarm_interrupt_logic;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic cfg_standby = 1'b1;
    logic cfg_alert_mask = 1'b1;
    logic cfg_second_hot = 1'b0;
    logic one_shot_wr = 1'b0;
    logic status_clear = 1'b0;
    logic reg_wr = 1'b0;
    logic [1:0] reg_sel = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic conv_done = 1'b0;
    logic open_cmp_i = 1'b0;
    tal_pkg::tal_limits_s limits = {8'h7f, 8'h00, 8'h7f, 8'h00};
    tal_pkg::tal_temps_s meas = 16'h0000;
    tal_pkg::tal_temps_s values;
    logic scl, host_pull, sda_o, sda_oe, conv_start, conv_abort, ara_won;
    logic fs_o, fs_oe, sh_o, sh_oe, ack_n;
    int wins = 0;
    logic [7:0] local_hot_limit, remote_hot_limit, hyst, status, rd;
    int err_total = 0;
    int samples_checked = 0;
    int fe_cnt = 0;
    int starts = 0;
    int aborts = 0;
    // Open-drain line with pull-up: low if anyone pulls
    wire sda_line = ~(host_pull | sda_oe);
    always #2.5 sys_clk = ~sys_clk;
    tal_host_model host (.scl(scl), .sda_pull(host_pull), .sda(sda_line));
    tal_alarm #(.CONV_PERIOD(50)) DUT (
        .sys_clk(sys_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .own_addr(7'h4c), .cfg_standby(cfg_standby),
        .cfg_alert_mask(cfg_alert_mask), .cfg_second_hot(cfg_second_hot),
        .one_shot_wr(one_shot_wr), .limits(limits), .status_clear(status_clear),
        .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
        .local_hot_limit(local_hot_limit), .remote_hot_limit(remote_hot_limit),
        .hyst(hyst), .conv_start(conv_start), .conv_abort(conv_abort),
        .conv_done(conv_done), .meas(meas), .open_cmp_i(open_cmp_i), .values(values),
        .status(status), .ara_won(ara_won), .failsafe_hot_n_o(fs_o),
        .failsafe_hot_n_oe(fs_oe), .shared_n_o(sh_o), .shared_n_oe(sh_oe));
    // Front end answers late enough that an abort lands first
    always @(posedge sys_clk)
    begin
        conv_done <= (fe_cnt == 1);
        if (conv_start === 1'b1)
            fe_cnt <= 6;
        else if (conv_abort === 1'b1)
            fe_cnt <= 0;
        else if (fe_cnt > 0)
            fe_cnt <= fe_cnt - 1;
        if (conv_start === 1'b1)
            starts++;
        if (conv_abort === 1'b1)
            aborts++;
        if (ara_won === 1'b1)
            wins++;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic conv_once(input logic [7:0] lt, input logic [7:0] rt);
        int i;
        meas = {lt, rt};
        one_shot_wr = 1'b1;
        tick(1);
        one_shot_wr = 1'b0;
        for (i = 0; i < 40 && conv_done !== 1'b1; i++)
            tick(1);
        if (i == 40)
            err_total++;
        if (i == 40)
            report_and_stop();
        tick(5);
        `CHK(values, {lt, rt})
    endtask
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_sel = sel;
        reg_wdata = d;
        tick(1);
        reg_wr = 1'b0;
        tick(4);
    endtask
    task automatic clr();
        tick(2);
        status_clear = 1'b1;
        tick(1);
        status_clear = 1'b0;
        tick(4);
    endtask
    task automatic ara(input logic [7:0] rival);
        host.ara_read(rival, rd, ack_n);
        tick(5);
    endtask
    initial
    begin
        int i;
        repeat (20) @(posedge sys_clk);
        #1 rstn = 1'b1;
        tick(2);
        `CHK({local_hot_limit, remote_hot_limit}, 16'h5555)
        `CHK(hyst, 8'h0a)
        `CHK({sda_o, fs_o, sh_o, fs_oe, sh_oe}, 5'h00)
        conv_once(8'h1e, 8'h28);
        tick(100);
        `CHK(starts, 1)
        limits = {8'h7f, 8'h0a, 8'h7f, 8'h0a};
        clr();
        `CHK(status, 8'h00)
        cfg_alert_mask = 1'b0;
        limits.local_high = 8'h14;
        tick(5);
        `CHK({status[6], sh_oe}, 2'b11)
        ara(8'hff);
        `CHK(rd, 8'h99)
        `CHK({ack_n, sh_oe}, 2'b01)
        `CHK(wins, 1)
        limits.local_high = 8'h7f;
        tick(5);
        `CHK({status[6], sh_oe}, 2'b11)
        clr();
        `CHK({status, sh_oe}, 9'h000)
        limits.remote_low = 8'h28;
        tick(5);
        `CHK({status[3], sh_oe}, 2'b11)
        // A lower rival address wins the answer
        ara(8'h31);
        `CHK({wins == 1, sh_oe}, 2'b11)
        ara(8'hff);
        `CHK(wins, 2)
        limits.remote_low = 8'h0a;
        clr();
        `CHK(sh_oe, 1'b0)
        cfg_alert_mask = 1'b1;
        limits.remote_high = 8'h14;
        tick(5);
        `CHK({status[4], sh_oe}, 2'b10)
        limits.remote_high = 8'h7f;
        clr();
        cfg_alert_mask = 1'b0;
        open_cmp_i = 1'b1;
        tick(4);
        conv_once(8'h1e, 8'h28);
        `CHK({status[2], sh_oe}, 2'b11)
        open_cmp_i = 1'b0;
        tick(4);
        conv_once(8'h1e, 8'h28);
        ara(8'hff);
        clr();
        `CHK(sh_oe, 1'b0)
        wr(tal_pkg::SEL_LOCAL_HOT, 8'h23);
        conv_once(8'h24, 8'h28);
        `CHK(fs_oe, 1'b1)
        conv_once(8'h1a, 8'h28);
        `CHK(fs_oe, 1'b1)
        conv_once(8'h19, 8'h28);
        `CHK(fs_oe, 1'b0)
        wr(tal_pkg::SEL_REMOTE_HOT, 8'h20);
        `CHK(fs_oe, 1'b1)
        conv_once(8'h19, 8'h16);
        `CHK(fs_oe, 1'b0)
        cfg_second_hot = 1'b1;
        cfg_alert_mask = 1'b1;
        limits.local_high = 8'h20;
        wr(tal_pkg::SEL_HYST, 8'h02);
        `CHK(hyst, 8'h02)
        conv_once(8'h21, 8'h16);
        `CHK(sh_oe, 1'b1)
        conv_once(8'h1f, 8'h16);
        `CHK(sh_oe, 1'b1)
        conv_once(8'h1e, 8'h16);
        `CHK(sh_oe, 1'b0)
        // New front-end data, so a conversion that is not aborted would show
        meas = 16'h3c3c;
        cfg_standby = 1'b0;
        for (i = 0; i < 80 && conv_start !== 1'b1; i++)
            tick(1);
        `CHK(i < 80, 1'b1)
        cfg_standby = 1'b1;
        tick(10);
        `CHK(aborts, 1)
        `CHK(values, 16'h1e16)
        report_and_stop();
    end
endmodule
